// [hw/vib_filter_config.sv]
/*
 * configuration and selection logic of the vibration suppression stage:
 * four notch settings, adaptive notch override, four damping filters.
 * assumes settings and select inputs are synchronous to sys_clk, and the
 * adaptive estimator delivers notch 3/4 values on its own ports.
 */
`timescale 1ns/100ps
module vib_filter_config
  import vib_filter_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // setting write port
  input wire logic setting_write,
  input wire logic [2:0] adapt_mode_in,
  input wire logic [1:0] damp_sel_in,
  input wire logic [1:0] notch_index,
  input wire logic [FREQ_W-1:0] notch_freq_in,
  input wire logic [WIDTH_W-1:0] notch_width_in,
  input wire logic [DEPTH_W-1:0] notch_depth_in,
  input wire logic [1:0] damp_index,
  input wire logic [DAMP_W-1:0] damp_freq_in,
  input wire logic [DAMP_W-1:0] damp_trim_in,
  // adaptive estimator
  input wire logic adapt_done,
  input wire logic [FREQ_W-1:0] adapt_freq_a,
  input wire logic [FREQ_W-1:0] adapt_freq_b,
  input wire logic [WIDTH_W-1:0] adapt_width,
  input wire logic [DEPTH_W-1:0] adapt_depth,
  // selection inputs, high = shorted
  input wire logic damping_select_input_a,
  input wire logic damping_select_input_b,
  input wire logic reverse_rotation,
  // filter coefficients
  output logic [NOTCH_COUNT*FREQ_W-1:0] notch_freq,
  output logic [NOTCH_COUNT*WIDTH_W-1:0] notch_width,
  output logic [NOTCH_COUNT*DEPTH_W-1:0] notch_depth,
  output logic [DAMP_COUNT*DAMP_W-1:0] damp_freq,
  output logic [DAMP_COUNT*DAMP_W-1:0] damp_trim,
  output logic [DAMP_COUNT-1:0] damp_enable,
  // status
  output logic [1:0] adapt_notch_count,
  output logic adapt_freq_locked,
  output logic setting_clamped
);

  // ***********************************************************
  // stored settings
  // ***********************************************************
  logic [2:0] adapt_mode;
  logic [1:0] damp_sel;
  logic [FREQ_W-1:0] user_freq [NOTCH_COUNT];
  logic [WIDTH_W-1:0] user_width [NOTCH_COUNT];
  logic [DEPTH_W-1:0] user_depth [NOTCH_COUNT];
  logic [DAMP_W-1:0] dfreq [DAMP_COUNT];
  logic [DAMP_W-1:0] dtrim [DAMP_COUNT];
  logic locked;

  // ***********************************************************
  // range limiting of incoming writes
  // ***********************************************************
  logic [FREQ_W-1:0] c_freq;
  logic [WIDTH_W-1:0] c_width;
  logic [DEPTH_W-1:0] c_depth;
  logic [DAMP_W-1:0] c_dfreq;
  logic [DAMP_W-1:0] c_dtrim;
  logic o_freq;
  logic o_width;
  logic o_depth;
  logic o_dfreq;
  logic o_dtrim;

  setting_clamp #(.W(FREQ_W)) clamp_freq (
    .min_value(NOTCH_FREQ_MIN),
    .max_value(NOTCH_FREQ_MAX),
    .raw_value(notch_freq_in),
    .clamped_value(c_freq),
    .out_of_range(o_freq)
  );
  setting_clamp #(.W(WIDTH_W)) clamp_width (
    .min_value('0),
    .max_value(NOTCH_WIDTH_MAX),
    .raw_value(notch_width_in),
    .clamped_value(c_width),
    .out_of_range(o_width)
  );
  setting_clamp #(.W(DEPTH_W)) clamp_depth (
    .min_value('0),
    .max_value(NOTCH_DEPTH_MAX),
    .raw_value(notch_depth_in),
    .clamped_value(c_depth),
    .out_of_range(o_depth)
  );
  setting_clamp #(.W(DAMP_W)) clamp_dfreq (
    .min_value('0),
    .max_value(DAMP_FREQ_MAX),
    .raw_value(damp_freq_in),
    .clamped_value(c_dfreq),
    .out_of_range(o_dfreq)
  );
  setting_clamp #(.W(DAMP_W)) clamp_dtrim (
    .min_value('0),
    .max_value(DAMP_TRIM_MAX),
    .raw_value(damp_trim_in),
    .clamped_value(c_dtrim),
    .out_of_range(o_dtrim)
  );

  // illegal mode codes keep the previous mode rather than being clamped
  wire adapt_mode_ok = adapt_mode_in <= ADAPT_MODE_MAX;
  wire any_clamp = o_freq | o_width | o_depth | o_dfreq | o_dtrim | ~adapt_mode_ok;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adapt_mode <= ADAPT_OFF;
      damp_sel <= DAMP_SEL_ALL;
      for (int i = 0; i < NOTCH_COUNT; i++) begin
        user_freq[i] <= NOTCH_FREQ_DEF;
        user_width[i] <= NOTCH_WIDTH_DEF;
        user_depth[i] <= NOTCH_DEPTH_DEF;
      end
      for (int i = 0; i < DAMP_COUNT; i++) begin
        dfreq[i] <= DAMP_FREQ_DEF;
        dtrim[i] <= DAMP_TRIM_DEF;
      end
    end else if (setting_write) begin
      if (adapt_mode_ok) begin
        adapt_mode <= adapt_mode_in;
      end
      damp_sel <= damp_sel_in;
      user_freq[notch_index] <= c_freq;
      user_width[notch_index] <= c_width;
      user_depth[notch_index] <= c_depth;
      dfreq[damp_index] <= c_dfreq;
      dtrim[damp_index] <= c_dtrim;
    end
  end

  // ***********************************************************
  // adaptive notch control
  // ***********************************************************
  adapt_mode_e mode_e;
  assign mode_e = adapt_mode_e'(adapt_mode);

  logic [1:0] next_count;
  logic limited_mode;
  always_comb begin
    next_count = 2'h0;
    limited_mode = 1'b0;
    unique case (mode_e)
      ADAPT_OFF: next_count = 2'h0;
      ADAPT_ONE_LIMIT: begin
        next_count = 2'h1;
        limited_mode = 1'b1;
      end
      ADAPT_TWO_LIMIT: begin
        next_count = 2'h2;
        limited_mode = 1'b1;
      end
      ADAPT_ONE_CONT: next_count = 2'h1;
      ADAPT_TWO_CONT: next_count = 2'h2;
      default: next_count = 2'h0;
    endcase
  end

  // in limited modes the frequency freezes once the estimator reports done;
  // in mode 4 notch 4 freezes after done while notch 3 keeps adapting
  wire next_locked = (next_count == 2'h0) ? 1'b0 : (locked | adapt_done);
  wire freeze_a = limited_mode & locked;
  wire freeze_b = (limited_mode | (mode_e == ADAPT_TWO_CONT)) & locked;
  wire use_a = next_count != 2'h0;
  wire use_b = next_count == 2'h2;

  logic [FREQ_W-1:0] held_a;
  logic [FREQ_W-1:0] held_b;
  wire [FREQ_W-1:0] next_held_a = freeze_a ? held_a : adapt_freq_a;
  wire [FREQ_W-1:0] next_held_b = freeze_b ? held_b : adapt_freq_b;

  // ***********************************************************
  // damping selection
  // ***********************************************************
  function automatic logic [3:0] damp_pick(input logic [1:0] sel, input logic a,
                                           input logic b, input logic rev);
    logic [3:0] r;
    r = DAMP_ALL;
    unique case (damp_sel_e'(sel))
      DAMP_SEL_ALL: r = DAMP_ALL;
      DAMP_SEL_INPUT_A: r = a ? DAMP_EVEN : DAMP_ODD;
      DAMP_SEL_CODE: r = DAMP_ONE << {b, a};
      DAMP_SEL_DIRECTION: r = rev ? DAMP_EVEN : DAMP_ODD;
    endcase
    return r;
  endfunction : damp_pick

  wire [3:0] picked = damp_pick(damp_sel, damping_select_input_a,
                                damping_select_input_b, reverse_rotation);
  logic [3:0] next_damp_enable;
  always_comb begin
    next_damp_enable = DAMP_NONE;
    for (int i = 0; i < DAMP_COUNT; i++) begin
      next_damp_enable[i] = picked[i] & (dfreq[i] >= DAMP_FREQ_ACTIVE);
    end
  end

  // ***********************************************************
  // output registers
  // ***********************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked <= 1'b0;
      held_a <= NOTCH_FREQ_DEF;
      held_b <= NOTCH_FREQ_DEF;
      notch_freq <= {NOTCH_COUNT{NOTCH_FREQ_DEF}};
      notch_width <= {NOTCH_COUNT{NOTCH_WIDTH_DEF}};
      notch_depth <= {NOTCH_COUNT{NOTCH_DEPTH_DEF}};
      damp_freq <= {DAMP_COUNT{DAMP_FREQ_DEF}};
      damp_trim <= {DAMP_COUNT{DAMP_TRIM_DEF}};
      damp_enable <= DAMP_NONE;
      adapt_notch_count <= 2'h0;
      adapt_freq_locked <= 1'b0;
      setting_clamped <= 1'b0;
    end else begin
      locked <= next_locked;
      held_a <= next_held_a;
      held_b <= next_held_b;
      for (int i = 0; i < NOTCH_COUNT; i++) begin
        notch_freq[i*FREQ_W +: FREQ_W] <= user_freq[i];
        notch_width[i*WIDTH_W +: WIDTH_W] <= user_width[i];
        notch_depth[i*DEPTH_W +: DEPTH_W] <= user_depth[i];
      end
      if (use_a) begin
        notch_freq[ADAPT_NOTCH_A*FREQ_W +: FREQ_W] <= next_held_a;
        notch_width[ADAPT_NOTCH_A*WIDTH_W +: WIDTH_W] <= adapt_width;
        notch_depth[ADAPT_NOTCH_A*DEPTH_W +: DEPTH_W] <= adapt_depth;
      end
      if (use_b) begin
        notch_freq[ADAPT_NOTCH_B*FREQ_W +: FREQ_W] <= next_held_b;
        notch_width[ADAPT_NOTCH_B*WIDTH_W +: WIDTH_W] <= adapt_width;
        notch_depth[ADAPT_NOTCH_B*DEPTH_W +: DEPTH_W] <= adapt_depth;
      end
      for (int i = 0; i < DAMP_COUNT; i++) begin
        damp_freq[i*DAMP_W +: DAMP_W] <= dfreq[i];
        damp_trim[i*DAMP_W +: DAMP_W] <= dtrim[i];
      end
      damp_enable <= next_damp_enable;
      adapt_notch_count <= next_count;
      adapt_freq_locked <= next_locked & (limited_mode | (mode_e == ADAPT_TWO_CONT));
      setting_clamped <= setting_write & any_clamp;
    end
  end

endmodule : vib_filter_config

// [hw/vib_filter_pkg.sv]
/*
 * package for the vibration suppression filter configuration block:
 * setting widths, ranges, defaults and mode encodings.
 * assumes nothing of its surroundings.
 */
package vib_filter_pkg;

  // ***********************************************************
  // widths
  // ***********************************************************
  localparam int FREQ_W = 13;
  localparam int WIDTH_W = 5;
  localparam int DEPTH_W = 7;
  localparam int DAMP_W = 11;
  localparam int NOTCH_COUNT = 4;
  localparam int DAMP_COUNT = 4;

  // ***********************************************************
  // notch ranges and defaults
  // ***********************************************************
  localparam logic [FREQ_W-1:0] NOTCH_FREQ_MIN = 13'h0032;
  localparam logic [FREQ_W-1:0] NOTCH_FREQ_MAX = 13'h1388;
  localparam logic [FREQ_W-1:0] NOTCH_FREQ_DEF = 13'h1388;
  localparam logic [WIDTH_W-1:0] NOTCH_WIDTH_MAX = 5'h14;
  localparam logic [WIDTH_W-1:0] NOTCH_WIDTH_DEF = 5'h02;
  localparam logic [DEPTH_W-1:0] NOTCH_DEPTH_MAX = 7'h63;
  localparam logic [DEPTH_W-1:0] NOTCH_DEPTH_DEF = 7'h00;

  // ***********************************************************
  // damping ranges and defaults, 0.1 hz steps
  // ***********************************************************
  localparam logic [DAMP_W-1:0] DAMP_FREQ_MAX = 11'h7d0;
  localparam logic [DAMP_W-1:0] DAMP_FREQ_ACTIVE = 11'h00a;
  localparam logic [DAMP_W-1:0] DAMP_FREQ_DEF = 11'h000;
  localparam logic [DAMP_W-1:0] DAMP_TRIM_MAX = 11'h3e8;
  localparam logic [DAMP_W-1:0] DAMP_TRIM_DEF = 11'h000;

  // ***********************************************************
  // modes
  // ***********************************************************
  typedef enum logic [2:0] {
    ADAPT_OFF = 3'h0,
    ADAPT_ONE_LIMIT = 3'h1,
    ADAPT_TWO_LIMIT = 3'h2,
    ADAPT_ONE_CONT = 3'h3,
    ADAPT_TWO_CONT = 3'h4
  } adapt_mode_e;

  typedef enum logic [1:0] {
    DAMP_SEL_ALL = 2'h0,
    DAMP_SEL_INPUT_A = 2'h1,
    DAMP_SEL_CODE = 2'h2,
    DAMP_SEL_DIRECTION = 2'h3
  } damp_sel_e;

  localparam logic [2:0] ADAPT_MODE_MAX = 3'h4;
  localparam logic [3:0] DAMP_ODD = 4'h5;
  localparam logic [3:0] DAMP_EVEN = 4'ha;
  localparam logic [3:0] DAMP_NONE = 4'h0;
  localparam logic [3:0] DAMP_ALL = 4'hf;
  localparam logic [3:0] DAMP_ONE = 4'h1;
  localparam int ADAPT_NOTCH_A = 2;
  localparam int ADAPT_NOTCH_B = 3;

endpackage : vib_filter_pkg

// [hw/setting_clamp.sv]
/*
 * saturating limiter for one setting word.
 * assumes min is not above max; purely combinational.
 */
`timescale 1ns/100ps
module setting_clamp #(
  parameter int W = 13
) (
  // range
  input wire logic [W-1:0] min_value,
  input wire logic [W-1:0] max_value,
  // value
  input wire logic [W-1:0] raw_value,
  output logic [W-1:0] clamped_value,
  output logic out_of_range
);

  wire below = raw_value < min_value;
  wire above = raw_value > max_value;

  // clamp rather than reject, so a bad write still moves toward intent
  assign clamped_value = below ? min_value : (above ? max_value : raw_value);
  assign out_of_range = below | above;

endmodule : setting_clamp

// [test/vib_filter_config_assertions.sv]
/* checker: coefficient ranges, clamp flag, notch 1 write latency.
   assumes a bind onto vib_filter_config, one clock domain. */
`timescale 1ns/100ps
module vib_filter_config_assertions
  import vib_filter_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // write port
  input wire logic setting_write,
  input wire logic [1:0] notch_index,
  input wire logic [FREQ_W-1:0] notch_freq_in,
  input wire logic [WIDTH_W-1:0] notch_width_in,
  input wire logic [DEPTH_W-1:0] notch_depth_in,
  input wire logic [WIDTH_W-1:0] adapt_width,
  // results
  input wire logic [NOTCH_COUNT*FREQ_W-1:0] notch_freq,
  input wire logic [NOTCH_COUNT*WIDTH_W-1:0] notch_width,
  input wire logic [NOTCH_COUNT*DEPTH_W-1:0] notch_depth,
  input wire logic [DAMP_COUNT*DAMP_W-1:0] damp_freq,
  input wire logic [DAMP_COUNT*DAMP_W-1:0] damp_trim,
  input wire logic [1:0] adapt_notch_count,
  input wire logic setting_clamped
);
  // ********
  // helpers
  // ********
  logic n_ok;
  logic d_ok;
  logic bad;
  always_comb begin
    n_ok = 1'b1;
    d_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (notch_freq[i*13 +: 13] < NOTCH_FREQ_MIN) n_ok = 1'b0;
      if (notch_freq[i*13 +: 13] > NOTCH_FREQ_MAX) n_ok = 1'b0;
      if (notch_width[i*5 +: 5] > NOTCH_WIDTH_MAX) n_ok = 1'b0;
      if (notch_depth[i*7 +: 7] > NOTCH_DEPTH_MAX) n_ok = 1'b0;
      if (damp_freq[i*11 +: 11] > DAMP_FREQ_MAX) d_ok = 1'b0;
      if (damp_trim[i*11 +: 11] > DAMP_TRIM_MAX) d_ok = 1'b0;
    end
  end
  assign bad = notch_freq_in < NOTCH_FREQ_MIN || notch_freq_in > NOTCH_FREQ_MAX
    || notch_width_in > NOTCH_WIDTH_MAX || notch_depth_in > NOTCH_DEPTH_MAX;
  // ********
  // properties
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet; !setting_write ##1 !setting_write; endsequence
  sequence s_wr0; setting_write && notch_index == 2'h0 && !bad; endsequence
  sequence s_deep1; setting_write && notch_index == 2'h1 && notch_depth_in > 7'h63; endsequence
  property p_n_rng; n_ok; endproperty
  property p_d_rng; d_ok; endproperty
  property p_cnt; adapt_notch_count != 2'h3; endproperty
  property p_wr0; s_wr0 |-> ##2 notch_freq[12:0] == $past(notch_freq_in, 2); endproperty
  property p_hold0; s_quiet |=> $stable(notch_freq[12:0]); endproperty
  property p_deep1; s_deep1 |-> ##2 notch_depth[13:7] == 7'h63; endproperty
  property p_clamp; setting_write && bad |=> setting_clamped; endproperty
  property p_idle; !setting_write |=> !setting_clamped; endproperty
  property p_shape; adapt_notch_count != 2'h0 |-> notch_width[14:10] == $past(adapt_width); endproperty
  a_n_rng: assert property (p_n_rng) else $error("notch value out of range");
  a_d_rng: assert property (p_d_rng) else $error("damping value out of range");
  a_cnt: assert property (p_cnt) else $error("adaptive count above two");
  a_wr0: assert property (p_wr0) else $error("notch 1 write lost");
  a_hold0: assert property (p_hold0) else $error("notch 1 moved unwritten");
  a_deep1: assert property (p_deep1) else $error("depth not clamped");
  a_clamp: assert property (p_clamp) else $error("clamp flag missing");
  a_idle: assert property (p_idle) else $error("clamp flag without write");
  a_shape: assert property (p_shape) else $error("adaptive width not followed");
endmodule : vib_filter_config_assertions
bind vib_filter_config vib_filter_config_assertions vib_filter_config_assertions_i (.sys_clk,
  .rst_n, .setting_write, .notch_index, .notch_freq_in, .notch_width_in, .notch_depth_in,
  .adapt_width,
  .notch_freq, .notch_width, .notch_depth, .damp_freq, .damp_trim, .adapt_notch_count,
  .setting_clamped);

// [test/vib_partner_model.sv]
/* far side: select lines, rotation and a drifting notch estimator.
   assumes the bench steers it off the rising edge. */
`timescale 1ns/100ps
module vib_partner_model
  import vib_filter_pkg::*;
(
  // bench control
  input wire logic sys_clk,
  input wire logic [2:0] line_cmd,
  input wire logic done_cmd,
  // to the block
  output logic [2:0] lines,
  output logic done,
  output logic [FREQ_W-1:0] freq_a,
  output logic [FREQ_W-1:0] freq_b,
  output logic [WIDTH_W-1:0] width,
  output logic [DEPTH_W-1:0] depth
);
  logic [7:0] drift = 8'h00;
  // estimates move each cycle so frozen and tracking notches differ
  always @(negedge sys_clk) drift <= drift + 8'h01;
  assign freq_a = 13'h03e8 + 13'(drift);
  assign freq_b = 13'h07d0 + 13'(drift);
  assign width = 5'h04;
  assign depth = 7'h1e;
  assign lines = line_cmd;
  assign done = done_cmd;
endmodule : vib_partner_model

// [test/tb_vib_filter_config.sv]
/* bench: reset values, clamped writes, damping selection, adaptive modes.
   assumes package, design, checker and partner compiled first. */
`timescale 1ns/100ps
module tb_vib_filter_config;
  import vib_filter_pkg::*;
  logic sys_clk, rst_n, setting_write, done_cmd, clamp_seen, adapt_freq_locked, setting_clamped;
  wire damping_select_input_a, damping_select_input_b, reverse_rotation, adapt_done;
  wire [FREQ_W-1:0] adapt_freq_a, adapt_freq_b;
  wire [WIDTH_W-1:0] adapt_width;
  wire [DEPTH_W-1:0] adapt_depth;
  logic [2:0] adapt_mode_in, line_cmd;
  logic [1:0] damp_sel_in, notch_index, damp_index, adapt_notch_count;
  logic [FREQ_W-1:0] notch_freq_in;
  logic [WIDTH_W-1:0] notch_width_in;
  logic [DEPTH_W-1:0] notch_depth_in;
  logic [DAMP_W-1:0] damp_freq_in, damp_trim_in;
  logic [51:0] notch_freq;
  logic [19:0] notch_width;
  logic [27:0] notch_depth;
  logic [43:0] damp_freq, damp_trim;
  logic [3:0] damp_enable;
  int n_fail = 0, n_checks = 0, cycles = 0;
  vib_filter_config vib_filter_config_i (.sys_clk, .rst_n, .setting_write, .adapt_mode_in,
    .damp_sel_in, .notch_index, .notch_freq_in, .notch_width_in, .notch_depth_in, .damp_index,
    .damp_freq_in, .damp_trim_in, .adapt_done, .adapt_freq_a, .adapt_freq_b, .adapt_width,
    .adapt_depth, .damping_select_input_a, .damping_select_input_b, .reverse_rotation,
    .notch_freq, .notch_width, .notch_depth, .damp_freq, .damp_trim, .damp_enable,
    .adapt_notch_count, .adapt_freq_locked, .setting_clamped);
  vib_partner_model vib_partner_model_i (.sys_clk, .line_cmd, .done_cmd,
    .lines({damping_select_input_b, damping_select_input_a, reverse_rotation}),
    .done(adapt_done), .freq_a(adapt_freq_a), .freq_b(adapt_freq_b),
    .width(adapt_width), .depth(adapt_depth));
  // ********
  // tasks
  // ********
  function automatic logic [15:0] nf(input int i);
    return {3'h0, notch_freq[i*13 +: 13]};
  endfunction : nf
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic pulse();
    @(negedge sys_clk) setting_write = 1'b1;
    @(negedge sys_clk) setting_write = 1'b0;
    clamp_seen = setting_clamped;
    repeat (3) @(negedge sys_clk);
  endtask : pulse
  task automatic notch(input logic [1:0] i, input logic [24:0] v, input logic [24:0] e,
      input logic ec);
    {notch_freq_in, notch_width_in, notch_depth_in} = v;
    notch_index = i;
    pulse();
    chk("freq", nf(i), e[24:12]);
    chk("width", notch_width[i*5 +: 5], e[11:7]);
    chk("depth", notch_depth[i*7 +: 7], e[6:0]);
    chk("clamp", clamp_seen, ec);
  endtask : notch
  task automatic damp(input logic [1:0] i, input logic [21:0] v, input logic [21:0] e);
    {damp_freq_in, damp_trim_in} = v;
    damp_index = i;
    pulse();
    chk("damp freq", damp_freq[i*11 +: 11], e[21:11]);
    chk("trim", damp_trim[i*11 +: 11], e[10:0]);
  endtask : damp
  task automatic adapt(input logic [2:0] m, input logic [1:0] ec, input logic el, input logic mv);
    logic [15:0] s0;
    logic [15:0] s1;
    adapt_mode_in = m;
    pulse();
    chk("count", adapt_notch_count, ec);
    chk("lock", adapt_freq_locked, el);
    s0 = nf(2);
    s1 = nf(3);
    repeat (2) @(negedge sys_clk);
    chk("notch 3 moves", nf(2) !== s0, mv);
    chk("notch 4 held", nf(3), s1);
  endtask : adapt
  function automatic logic [3:0] sel(input int m, input int l);
    case (m)
      0: sel = DAMP_ALL;
      1: sel = l[1] ? DAMP_EVEN : DAMP_ODD;
      2: sel = DAMP_ONE << l[2:1];
      default: sel = l[0] ? DAMP_EVEN : DAMP_ODD;
    endcase
  endfunction : sel
  // ********
  // sequence
  // ********
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    {rst_n, setting_write, done_cmd, line_cmd, adapt_mode_in, damp_sel_in, notch_index} = '0;
    {notch_freq_in, notch_width_in, notch_depth_in, damp_index, damp_freq_in} = '0;
    {damp_trim_in, clamp_seen} = '0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk("reset notch", {nf(i)}, NOTCH_FREQ_DEF);
      chk("reset shape", {notch_width[i*5 +: 5], notch_depth[i*7 +: 7]}, 12'h100);
      chk("reset damp", damp_freq[i*11 +: 11] | damp_trim[i*11 +: 11], 11'h000);
    end
    chk("reset enable", damp_enable, DAMP_NONE);
    notch(2'h0, {13'h0032, 5'h00, 7'h63}, {13'h0032, 5'h00, 7'h63}, 1'b0);
    notch(2'h1, {13'h1388, 5'h14, 7'h00}, {13'h1388, 5'h14, 7'h00}, 1'b0);
    notch(2'h2, {13'h04d2, 5'h07, 7'h32}, {13'h04d2, 5'h07, 7'h32}, 1'b0);
    notch(2'h3, {13'h0309, 5'h03, 7'h01}, {13'h0309, 5'h03, 7'h01}, 1'b0);
    notch(2'h0, {13'h0031, 5'h15, 7'h64}, {13'h0032, 5'h14, 7'h63}, 1'b1);
    notch(2'h1, {13'h1770, 5'h1f, 7'h78}, {13'h1388, 5'h14, 7'h63}, 1'b1);
    notch(2'h0, {13'h0064, 5'h01, 7'h00}, {13'h0064, 5'h01, 7'h00}, 1'b0);
    damp(2'h0, {11'h009, 11'h000}, {11'h009, 11'h000});
    damp(2'h1, {11'h00a, 11'h3e8}, {11'h00a, 11'h3e8});
    damp(2'h2, {11'h7ff, 11'h4b0}, {11'h7d0, 11'h3e8});
    damp(2'h3, {11'h064, 11'h001}, {11'h064, 11'h001});
    for (int m = 0; m < 4; m++) begin
      damp_sel_in = 2'(m);
      pulse();
      for (int l = 0; l < 8; l++) begin
        line_cmd = 3'(l);
        repeat (2) @(negedge sys_clk);
        chk("enable", damp_enable, sel(m, l) & 4'he);
      end
    end
    adapt(3'h3, 2'h1, 1'b0, 1'b1);
    chk("adaptive shape", {notch_width[14:10], notch_depth[20:14]}, 12'h21e);
    chk("notch 4 user", nf(3), 13'h0309);
    done_cmd = 1'b1;
    adapt(3'h4, 2'h2, 1'b1, 1'b1);
    chk("notch 4 estimate", nf(3) >= 16'h07d0, 1'b1);
    adapt(3'h1, 2'h1, 1'b1, 1'b0);
    adapt(3'h2, 2'h2, 1'b1, 1'b0);
    adapt(3'h5, 2'h2, 1'b1, 1'b0);
    chk("mode refused", clamp_seen, 1'b1);
    done_cmd = 1'b0;
    adapt(3'h0, 2'h0, 1'b0, 1'b0);
    chk("user notch 3", nf(2), 16'h04d2);
    chk("user notch 4", nf(3), 16'h0309);
    results();
  end
endmodule : tb_vib_filter_config
